/* File: bench/upe_usb_dev.sv */
// Behavioural model of the device attached to the downstream port.
// Assumes the bench commands attach, speed and remote wakeup off the rising edge.
`timescale 1ns/1ns
module upe_usb_dev #(
    parameter int WAKE_CYC = 12 // Length of the wakeup K-state, shortened.
) (
    input  wire logic          clk,  // Core clock.
    input  wire logic          plug, // Device attached while high.
    input  wire logic [1:0]    spd,  // Speed code the device reports.
    input  wire logic          wake, // Request a remote wakeup.
    output upe_pkg::upe_line_t line  // Port pins toward the block.
);
    import upe_pkg::*;
    int wake_left = 0;
    // Counts out the K-state of a wakeup request.
    always @(posedge clk) begin
        if (wake && plug) begin
            wake_left <= WAKE_CYC;
        end else if (wake_left > 0) begin
            wake_left <= wake_left - 1;
        end
    end
    // Detached lines fall to SE0 through the pull-downs; idle is J, wakeup is K.
    always_comb begin
        line.attached = plug;
        line.speed = plug ? spd : 2'h0;
        if (!plug) begin
            line.line_state = 2'h0;
        end else if (wake_left > 0) begin
            line.line_state = LINE_K;
        end else begin
            line.line_state = LINE_J;
        end
    end
endmodule : upe_usb_dev

/* File: bench/usb_port_ctrl_eof_timing_tb_top.sv */
// Self-checking bench for the port control and frame end timing block.
// Assumes a small sleep step and a high-speed device model on the port.
`timescale 1ns/1ns
module usb_port_ctrl_eof_timing_tb_top;
    import upe_pkg::*;
    logic        clk, rst, reg_wr, reg_rd, sleep_start, plug, wake, rd_take;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rnd;
    logic        port_change, resume_drive, reset_drive, xcvr_susp_n;
    logic        port_enabled, port_susp, sleep_done;
    upe_line_t   line_in;
    upe_frame_t  frame;
    logic [31:0] exp_q[$];
    int          bad_count, checks_done, pc_count, n;
    time         sof_last, sof_prev;

    upe_port_ctrl #(.SLEEP_STEP(4)) upe_port_ctrl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .line_in(line_in), .port_change(port_change), .resume_drive(resume_drive),
        .reset_drive(reset_drive), .xcvr_susp_n(xcvr_susp_n), .port_enabled(port_enabled),
        .port_susp(port_susp), .frame(frame), .sleep_start(sleep_start), .sleep_done(sleep_done));
    upe_usb_dev upe_usb_dev_i (.clk(clk), .plug(plug), .spd(SPD_HS), .wake(wake), .line(line_in));

    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results;
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    // Notes the expected word; the read watcher compares it.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd = 1'b0;
    endtask : rd

    // Cycles from an end point mark rising to the next frame start.
    task automatic measure(input int sel, input int ticks);
        int k;
        int e;
        e = ticks * 25 / 3;
        k = 0;
        while ((sel == 1 ? frame.past_eof1 : frame.past_eof2) !== 1'b0 && k < 40000) begin
            @(negedge clk);
            k++;
        end
        while ((sel == 1 ? frame.past_eof1 : frame.past_eof2) !== 1'b1 && k < 80000) begin
            @(negedge clk);
            k++;
        end
        k = 0;
        while (frame.sof !== 1'b1 && k < 8000) begin
            @(negedge clk);
            k++;
        end
        chk("eof lead", 32'(k > e - 12 && k < e + 12), 32'h1);
    endtask : measure

    // Read data lands one cycle after the strobe; compare against the oldest note.
    always @(posedge clk) rd_take <= reg_rd;
    always @(negedge clk) begin
        if (rd_take === 1'b1) begin
            chk("reg_rdata", reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD);
        end
    end
    // Counts change pulses and notes frame start times.
    always @(posedge clk) begin
        if (port_change === 1'b1) pc_count <= pc_count + 1;
        if (frame.sof === 1'b1) begin
            sof_prev <= sof_last;
            sof_last <= $time;
        end
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (95000) @(posedge clk);
        bad_count++;
        results();
    end

    // Main sequence of scenarios.
    initial begin
        {rst, reg_wr, reg_rd, sleep_start, plug, wake} = 6'h20;
        {reg_addr, reg_wdata, rd_take, pc_count, bad_count, checks_done} = '0;
        rnd = 32'hC28167E0;
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        rd(EOT_OFS, {25'h0, EOT_RESET});
        rd(PSC_OFS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            wr(EOT_OFS, rnd);
            chk("xcvr_susp_n", 32'(xcvr_susp_n), 32'(rnd[6]));
            wr({1'b1, rnd[14:8]}, ~rnd);
            rd({1'b1, rnd[14:8]}, 32'h0);
            rd(EOT_OFS, rnd & 32'h7F);
        end
        for (int c = 0; c < 4; c++) begin
            wr(EOT_OFS, 32'h40 | 32'(c));
            @(negedge clk) sleep_start = 1'b1;
            @(negedge clk) sleep_start = 1'b0;
            n = 1;
            while (sleep_done !== 1'b1 && n < 100) begin
                @(negedge clk);
                n++;
            end
            chk("sleep cycles", 32'(n >= (c + 1) * 4 - 1 && n <= (c + 1) * 4 + 2), 32'h1);
        end
        plug = 1'b1;
        repeat (6) @(negedge clk);
        rd(PSC_OFS, 32'h3);
        wr(PSC_OFS, 32'h2);
        wr(PSC_OFS, 32'h4);
        rd(PSC_OFS, 32'h1);
        // Earliest early point (720 ticks) suits the largest packets.
        wr(EOT_OFS, 32'h7D);
        wr(PSC_OFS, 32'h100);
        chk("reset_drive", 32'(reset_drive), 32'h1);
        repeat (8) @(negedge clk);
        wr(PSC_OFS, 32'h0);
        rd(PSC_OFS, 32'hD);
        chk("port_enabled", 32'(port_enabled), 32'h1);
        wr(PSC_OFS, 32'hC);
        rd(PSC_OFS, 32'h5);
        fork
            measure(1, 720);
            measure(2, 16);
        join
        wr(EOT_OFS, 32'h49);
        fork
            measure(1, 180);
            measure(2, 2);
        join
        chk("frame cycles", 32'((sof_last - sof_prev) / 4), 32'd31250);
        // No schedule runs in this bench while the port is suspended.
        wr(PSC_OFS, 32'h84);
        chk("port_susp", 32'(port_susp), 32'h1);
        @(negedge clk) wake = 1'b1;
        @(negedge clk) wake = 1'b0;
        repeat (20) @(negedge clk);
        chk("port_change count", 32'(pc_count), 32'h1);
        chk("resume_drive", 32'(resume_drive), 32'h1);
        rd(PSC_OFS, 32'hC5);
        wr(PSC_OFS, 32'h4);
        chk("port_susp", 32'(port_susp), 32'h0);
        rd(PSC_OFS, 32'h5);
        wr(PSC_OFS, 32'h84);
        wr(PSC_OFS, 32'h104);
        rd(PSC_OFS, 32'h109);
        wr(PSC_OFS, 32'h0);
        plug = 1'b0;
        repeat (6) @(negedge clk);
        rd(PSC_OFS, 32'hA);
        chk("port_enabled", 32'(port_enabled), 32'h0);
        repeat (3) @(negedge clk);
        chk("pending reads", 32'(exp_q.size()), 32'h0);
        results();
    end
endmodule : usb_port_ctrl_eof_timing_tb_top

/* File: verilog/upe_pkg.sv */
// Package for the port control and frame end timing block.
// Assumes a 250 MHz core clock and a 32-bit register port.
package upe_pkg;
    // Register offsets.
    localparam logic [7:0]  PSC_OFS        = 8'h30;
    localparam logic [7:0]  EOT_OFS        = 8'h34;
    // Port status and control bit positions.
    localparam int          PSC_CONN       = 0;
    localparam int          PSC_CONNECT_CHANGE_FLAG   = 1;
    localparam int          PSC_EN         = 2;
    localparam int          PSC_EN_CHG     = 3;
    localparam int          PSC_RESUME     = 6;
    localparam int          PSC_SUSP       = 7;
    localparam int          PSC_RESET      = 8;
    // Timing register fields and reset value.
    localparam int          EOT_SUSPN      = 6;
    localparam int          EOT_EOF2_LO    = 4;
    localparam int          EOT_EOF1_LO    = 2;
    localparam int          EOT_SLP_LO     = 0;
    localparam logic [6:0]  EOT_RESET      = 7'h41;
    // Line states and speeds.
    localparam logic [1:0]  LINE_J         = 2'h2;
    localparam logic [1:0]  LINE_K         = 2'h1;
    localparam logic [1:0]  SPD_HS         = 2'h2;
    localparam logic [1:0]  SPD_LS         = 2'h1;
    // Clock rates; the frame timer counts ticks of a derived 30 MHz rate.
    localparam logic [8:0]  CLK_MHZ        = 9'h0FA;
    localparam logic [8:0]  TICK_MHZ       = 9'h01E;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          SLEEP_STEP_NS  = 5000;
    localparam int          SLEEP_STEP_CYC = (SLEEP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Frame lengths in 30 MHz ticks: 125 us and 1 ms.
    localparam logic [15:0] FRAME_HS       = 16'h0EA6;
    localparam logic [15:0] FRAME_FS       = 16'h7530;
    // End of frame points in 30 MHz ticks before the next frame start.
    localparam logic [15:0] EOF2_HS [4]    = '{16'h0002, 16'h0004, 16'h0008, 16'h0010};
    localparam logic [15:0] EOF2_FS [4]    = '{16'h0014, 16'h0028, 16'h0050, 16'h00A0};
    localparam logic [15:0] EOF2_LS [4]    = '{16'h0028, 16'h0050, 16'h00A0, 16'h0140};
    localparam logic [15:0] EOF1_HS [4]    = '{16'h021C, 16'h0168, 16'h00B4, 16'h02D0};
    localparam logic [15:0] EOF1_FS [4]    = '{16'h0640, 16'h0578, 16'h04B0, 16'h5208};
    localparam logic [15:0] EOF1_LS [4]    = '{16'h0EA6, 16'h0DAC, 16'h0CB2, 16'h0FA0};

    // Port pins as seen from the transceiver.
    typedef struct packed {
        logic       attached;
        logic [1:0] line_state;
        logic [1:0] speed;
    } upe_line_t;

    // Frame timing marks toward the schedule logic.
    typedef struct packed {
        logic sof;
        logic past_eof1;
        logic past_eof2;
    } upe_frame_t;
endpackage : upe_pkg

/* File: verilog/upe_port_ctrl.sv */
// Port status and control, frame end timing and async sleep timer.
// Assumes line pins are asynchronous and the register port is on clk.
//
// Operation
// - Suspend clears when resume flag falls or port reset rises.
// - Software writes resume flag one to drive resume; resets to zero.
// - While suspended, a J-to-K transition sets the resume flag.
// - That hardware resume also signals port change to the status register.
// - Enable change sets on any enable change; write one clears it.
// - Connect change sets on connect status change; write one clears.
// - Connect present reads the live attach state.
// - Active-low transceiver suspend, reset one, zero enters low power.
// - High-speed late end point is 2, 4, 8 or 16 ticks.
// - Full-speed late end point is 20, 40, 80 or 160 ticks.
// - Low-speed late end point is 40, 80, 160 or 320 ticks.
// - High-speed early end point is 540, 360, 180 or 720 ticks.
// - Full-speed early end point is 1600, 1400, 1200 or 21000 ticks.
// - Low-speed early end point is 3750, 3500, 3250 or 4000 ticks.
// - Async sleep interval 5, 10, 15 or 20 us, reset code one.
// - Enable and suspend flags together encode the port state.
// - Port reset flag one drives bus reset until written zero.
`timescale 1ns/1ns
module upe_port_ctrl #(
    parameter int SLEEP_STEP = upe_pkg::SLEEP_STEP_CYC // Cycles per 5 us sleep step.
) (
    input  wire logic               clk,          // Core clock, 250 MHz.
    input  wire logic               rst,          // Asynchronous reset, active high.
    input  wire logic [7:0]         reg_addr,     // Register byte address.
    input  wire logic               reg_wr,       // Write strobe.
    input  wire logic               reg_rd,       // Read strobe.
    input  wire logic [31:0]        reg_wdata,    // Write data.
    output logic [31:0]             reg_rdata,    // Read data, one cycle after strobe.
    input  wire upe_pkg::upe_line_t line_in,      // Port pins, asynchronous.
    output logic                    port_change,  // Pulse to the controller status.
    output logic                    resume_drive, // Drive resume on the port.
    output logic                    reset_drive,  // Drive bus reset on the port.
    output logic                    xcvr_susp_n,  // Transceiver suspend, active low.
    output logic                    port_enabled, // Port is enabled.
    output logic                    port_susp,    // Port is suspended.
    output upe_pkg::upe_frame_t     frame,        // Frame timing marks.
    input  wire logic               sleep_start,  // Start an async sleep interval.
    output logic                    sleep_done    // Pulse when the interval ends.
);
    import upe_pkg::*;

    // Refuse a step that the sleep counter cannot hold.
    if (SLEEP_STEP < 1 || SLEEP_STEP * 4 > 65535) begin : g_bad_step
        $error("SLEEP_STEP out of range");
    end

    upe_line_t   line_s1_ff;
    upe_line_t   line_s2_ff;
    upe_line_t   line_prev_ff;
    logic        reset_ff;
    logic        en_ff;
    logic        nxt_en;
    logic        en_chg_ff;
    logic        connect_change_flag_ff;
    logic        resume_ff;
    logic        nxt_resume;
    logic        susp_ff;
    logic        change_ff;
    logic [6:0]  eot_ff;
    logic [31:0] rdata_ff;
    logic [8:0]  acc_ff;
    logic        tick_ff;
    logic [15:0] remain_ff;
    upe_frame_t  frame_ff;
    logic [15:0] sleep_cnt_ff;
    logic        sleep_done_ff;
    logic        psc_wr;
    logic        eot_wr;
    logic        reset_rise;
    logic        reset_fall;
    logic        resume_fall;
    logic        jk_seen;
    logic        running;
    logic [15:0] eof1_sel;
    logic [15:0] eof2_sel;
    logic [15:0] frame_len;
    logic [9:0]  acc_sum;

    // Two-stage synchroniser, then a history stage for edge detection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_s1_ff   <= '0;
            line_s2_ff   <= '0;
            line_prev_ff <= '0;
        end else begin
            line_s1_ff   <= line_in;
            line_s2_ff   <= line_s1_ff;
            line_prev_ff <= line_s2_ff;
        end
    end

    // Write decode and software edges on the port flags.
    assign psc_wr      = reg_wr && (reg_addr == PSC_OFS);
    assign eot_wr      = reg_wr && (reg_addr == EOT_OFS);
    assign reset_rise  = psc_wr && reg_wdata[PSC_RESET] && !reset_ff;
    assign reset_fall  = psc_wr && !reg_wdata[PSC_RESET] && reset_ff;
    assign resume_fall = psc_wr && !reg_wdata[PSC_RESUME] && resume_ff;
    assign jk_seen     = susp_ff && (line_prev_ff.line_state == LINE_J)
                         && (line_s2_ff.line_state == LINE_K);

    // Port reset flag is held by software; a detach does not end it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_ff <= 1'b0;
        end else if (psc_wr) begin
            reset_ff <= reg_wdata[PSC_RESET];
        end
    end

    // Enable comes only from the end of a reset with a device attached.
    always_comb begin
        nxt_en = en_ff;
        if (!line_s2_ff.attached || reset_rise) begin
            nxt_en = 1'b0;
        end else if (reset_fall) begin
            nxt_en = 1'b1;
        end else if (psc_wr && !reg_wdata[PSC_EN]) begin
            nxt_en = 1'b0;
        end
    end

    // Enable flag and its change flag; a new change beats the clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_ff     <= 1'b0;
            en_chg_ff <= 1'b0;
        end else begin
            en_ff <= nxt_en;
            if (nxt_en != en_ff) begin
                en_chg_ff <= 1'b1;
            end else if (psc_wr && reg_wdata[PSC_EN_CHG]) begin
                en_chg_ff <= 1'b0;
            end
        end
    end

    // Connect change flag; a new change beats the clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            connect_change_flag_ff <= 1'b0;
        end else if (line_s2_ff.attached != line_prev_ff.attached) begin
            connect_change_flag_ff <= 1'b1;
        end else if (psc_wr && reg_wdata[PSC_CONNECT_CHANGE_FLAG]) begin
            connect_change_flag_ff <= 1'b0;
        end
    end

    // Resume flag: software drives it, remote wakeup sets it.
    always_comb begin
        nxt_resume = resume_ff;
        if (jk_seen) begin
            nxt_resume = 1'b1;
        end else if (psc_wr) begin
            nxt_resume = reg_wdata[PSC_RESUME];
        end
    end

    // Resume flag and the port change pulse on a wakeup rise.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resume_ff <= 1'b0;
            change_ff <= 1'b0;
        end else begin
            resume_ff <= nxt_resume;
            change_ff <= jk_seen && !resume_ff;
        end
    end

    // Suspend: set by software on an enabled port, written zero is ignored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            susp_ff <= 1'b0;
        end else if (resume_fall || reset_rise || !nxt_en) begin
            susp_ff <= 1'b0;
        end else if (psc_wr && reg_wdata[PSC_SUSP] && en_ff) begin
            susp_ff <= 1'b1;
        end
    end

    // Timing register; only the defined bits are stored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eot_ff <= EOT_RESET;
        end else if (eot_wr) begin
            eot_ff <= reg_wdata[6:0];
        end
    end

    // Read data, registered; unmapped addresses read zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            rdata_ff <= '0;
            if (reg_addr == PSC_OFS) begin
                rdata_ff[PSC_CONN]     <= line_s2_ff.attached;
                rdata_ff[PSC_CONNECT_CHANGE_FLAG] <= connect_change_flag_ff;
                rdata_ff[PSC_EN]       <= en_ff;
                rdata_ff[PSC_EN_CHG]   <= en_chg_ff;
                rdata_ff[PSC_RESUME]   <= resume_ff;
                rdata_ff[PSC_SUSP]     <= susp_ff;
                rdata_ff[PSC_RESET]    <= reset_ff;
            end else if (reg_addr == EOT_OFS) begin
                rdata_ff[6:0] <= eot_ff;
            end
        end
    end

    // 30 MHz tick from the core clock by a fractional accumulator.
    assign acc_sum = {1'b0, acc_ff} + {1'b0, TICK_MHZ};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (acc_sum >= {1'b0, CLK_MHZ}) begin
            acc_ff  <= 9'(acc_sum - {1'b0, CLK_MHZ});
            tick_ff <= 1'b1;
        end else begin
            acc_ff  <= acc_sum[8:0];
            tick_ff <= 1'b0;
        end
    end

    // End point and frame length selection by speed and code.
    always_comb begin
        case (line_s2_ff.speed)
            SPD_HS: begin
                eof2_sel  = EOF2_HS[eot_ff[EOT_EOF2_LO +: 2]];
                eof1_sel  = EOF1_HS[eot_ff[EOT_EOF1_LO +: 2]];
                frame_len = FRAME_HS;
            end
            SPD_LS: begin
                eof2_sel  = EOF2_LS[eot_ff[EOT_EOF2_LO +: 2]];
                eof1_sel  = EOF1_LS[eot_ff[EOT_EOF1_LO +: 2]];
                frame_len = FRAME_FS;
            end
            default: begin
                eof2_sel  = EOF2_FS[eot_ff[EOT_EOF2_LO +: 2]];
                eof1_sel  = EOF1_FS[eot_ff[EOT_EOF1_LO +: 2]];
                frame_len = FRAME_FS;
            end
        endcase
    end

    // Frame timer counts ticks down to the next frame start.
    assign running = en_ff && !susp_ff && !reset_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain_ff <= '0;
            frame_ff  <= '0;
        end else if (!running) begin
            remain_ff <= '0;
            frame_ff  <= '0;
        end else begin
            frame_ff.sof       <= tick_ff && (remain_ff == '0);
            frame_ff.past_eof1 <= remain_ff < eof1_sel;
            frame_ff.past_eof2 <= remain_ff < eof2_sel;
            if (tick_ff) begin
                remain_ff <= (remain_ff == '0) ? 16'(frame_len - 16'h0001)
                                               : 16'(remain_ff - 16'h0001);
            end
        end
    end

    // Async sleep timer: (code + 1) steps of 5 us.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_cnt_ff  <= '0;
            sleep_done_ff <= 1'b0;
        end else if (sleep_start) begin
            sleep_cnt_ff  <= 16'((32'(eot_ff[EOT_SLP_LO +: 2]) + 1) * SLEEP_STEP);
            sleep_done_ff <= 1'b0;
        end else begin
            sleep_done_ff <= sleep_cnt_ff == 16'h0001;
            if (sleep_cnt_ff != '0) begin
                sleep_cnt_ff <= 16'(sleep_cnt_ff - 16'h0001);
            end
        end
    end

    // Outputs.
    assign reg_rdata    = rdata_ff;
    assign port_change  = change_ff;
    assign resume_drive = resume_ff;
    assign reset_drive  = reset_ff;
    assign xcvr_susp_n  = eot_ff[EOT_SUSPN];
    assign port_enabled = en_ff;
    assign port_susp    = en_ff && susp_ff;
    assign frame        = frame_ff;
    assign sleep_done   = sleep_done_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wakeup;
        susp_ff && !resume_ff && (line_prev_ff.line_state == LINE_J)
        && (line_s2_ff.line_state == LINE_K);
    endsequence

    sequence s_reset_end;
        psc_wr && !reg_wdata[PSC_RESET] && reset_ff && line_s2_ff.attached
        ##1 line_s2_ff.attached;
    endsequence

    a_resume_ends_susp: assert property (resume_fall |=> !susp_ff)
        else $error("suspend not cleared on resume fall");
    a_reset_ends_susp: assert property (reset_rise |=> !susp_ff && !en_ff)
        else $error("suspend not cleared on reset rise");
    a_wakeup_flags: assert property (s_wakeup |=> resume_ff && port_change)
        else $error("wakeup did not set resume and change");
    a_change_once: assert property (port_change |=> !port_change)
        else $error("port change pulse longer than one cycle");
    a_sw_no_enable: assert property (psc_wr && reg_wdata[PSC_EN] && !en_ff
        && !reset_fall |=> !en_ff)
        else $error("software write enabled the port");
    a_enable_after_reset: assert property (s_reset_end |-> en_ff && en_chg_ff)
        else $error("reset end did not enable port");
    a_conn_change: assert property (line_s2_ff.attached != line_prev_ff.attached
        |=> connect_change_flag_ff)
        else $error("connect change flag not set");
    a_conn_read: assert property (reg_rd && reg_addr == PSC_OFS
        |=> reg_rdata[PSC_CONN] == $past(line_s2_ff.attached))
        else $error("connect status reads wrong");
    a_xcvr_write: assert property (eot_wr |=> xcvr_susp_n == $past(reg_wdata[EOT_SUSPN]))
        else $error("transceiver suspend not written");
    a_eof_nesting: assert property (frame.past_eof2 |-> frame.past_eof1)
        else $error("late end point before early end point");
    a_sleep_zero: assert property (sleep_start && eot_ff[1:0] == 2'h0
        ##1 !sleep_start [*2] |-> sleep_cnt_ff == 16'(SLEEP_STEP - 1))
        else $error("sleep interval length wrong");
endmodule : upe_port_ctrl
